// ==== hdl/anps_params.svh ====
// Constants for the partner status register bank
// Summary of operation
// R1 - Base page top bit shows partner multi-page ability
// R2 - Acknowledge bit copied from received word
// R3 - Remote fault and pause bits copied read-only
// R4 - Technology ability bits copied read-only
// R5 - Five-bit selector code in low bits
// R6 - Base page flag latches high when received
// R7 - Base page flag follows negotiation sync
// R8 - Parallel detection fault latches high
// R9 - Partner next page able bit shown
// R10 - Local next page able defaults to one
// R11 - Page received latches; cleared on expansion read
// R12 - Alternate mode also clears on page drop
// R13 - Store word in base or next page register
// R14 - Partner auto-negotiation able bit shown
// R15 - Next page register top bit shows more pages
// R16 - Reserved read zero; latches clear after read
`ifndef ANPS_PARAMS_SVH
`define ANPS_PARAMS_SVH
`define ANPS_ADDR_BASE 5'h05
`define ANPS_ADDR_EXP 5'h06
`define ANPS_ADDR_NEXT 5'h08
`define ANPS_BASE_RSVD_MASK 16'hEFFF
`define ANPS_ZERO16 16'h0000
`define ANPS_BIT_ANABLE 0
`define ANPS_BIT_PAGE_RX 1
`define ANPS_BIT_NP_ABLE 2
`define ANPS_BIT_LP_NP_ABLE 3
`define ANPS_BIT_PD_FAULT 4
`define ANPS_BIT_BASE_PAGE 5
`define ANPS_BIT_LP_NP 15
`define ANPS_BIT_RSVD 12
`define ANPS_LOCAL_NP_RESET 1'b1
`endif

// ==== hdl/anps_pkg.sv ====
// Types for the partner status register bank
package anps_pkg;
  typedef logic [15:0] anps_word_t;
  typedef logic [4:0] anps_addr_t;
endpackage

// ==== hdl/anps_latch.sv ====
// One latching-high flag with clear on read
`timescale 1ns/1ps
`default_nettype none
module anps_latch
  import anps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event and clears
  input wire logic set_evt,
  input wire logic rd_clr,
  input wire logic hw_clr,
  // Flag
  output logic flag
);
  logic next_flag;

  // Set wins over a read clear so no event is lost; a hardware clear wins over all
  always_comb
  begin
    next_flag = flag;
    if (rd_clr)
    begin
      next_flag = 1'b0; // R16
    end
    if (set_evt)
    begin
      next_flag = 1'b1; // R16
    end
    if (hw_clr)
    begin
      next_flag = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/anps_regs.sv ====
// Partner ability and expansion status registers for auto-negotiation
`timescale 1ns/1ps
`default_nettype none
`include "anps_params.svh"
module anps_regs
  import anps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management read port
  input wire logic rd_en,
  input wire anps_addr_t rd_addr,
  output anps_word_t rd_data,
  // From negotiation engine
  input wire logic page_rx_evt,
  input wire logic page_is_next,
  input wire anps_word_t rx_word,
  input wire logic base_page_evt,
  input wire logic pd_fault_evt,
  input wire logic lp_an_able,
  input wire logic mr_page_rx,
  input wire logic transmit_disable,
  // Configuration
  input wire logic alt_np_en,
  // Decoded views
  output logic latch_high_page_rx,
  output logic next_page_flag
);
  anps_word_t base_page; // Received base page word
  anps_word_t next_pg; // Received next page word
  anps_word_t next_base_page;
  anps_word_t next_next_pg;
  anps_word_t next_rd_data;
  logic lp_np_able; // Partner next page able
  logic an_able; // Partner autoneg able
  logic local_np; // Local next page able
  logic next_lp_np_able;
  logic next_an_able;
  logic base_flag;
  logic pd_flag;
  logic exp_rd;
  logic alt_clr;

  // Read of the expansion register clears its latched flags
  assign exp_rd = rd_en && (rd_addr == `ANPS_ADDR_EXP); // R11
  // Alternate mode drops the received flag when the page goes away
  assign alt_clr = alt_np_en && (!mr_page_rx || transmit_disable); // R12

  // Page received flag
  anps_latch u_page_rx (
    .clk(clk),
    .rst_n(rst_n),
    .set_evt(page_rx_evt), // R11
    .rd_clr(exp_rd),
    .hw_clr(alt_clr),
    .flag(latch_high_page_rx)
  );

  // Base page flag, synchronised to negotiation progress
  anps_latch u_base (
    .clk(clk),
    .rst_n(rst_n),
    .set_evt(base_page_evt), // R6 R7
    .rd_clr(exp_rd),
    .hw_clr(1'b0),
    .flag(base_flag)
  );

  // Parallel detection fault flag
  anps_latch u_pdf (
    .clk(clk),
    .rst_n(rst_n),
    .set_evt(pd_fault_evt), // R8
    .rd_clr(exp_rd),
    .hw_clr(1'b0),
    .flag(pd_flag)
  );

  // Page capture and partner ability tracking
  always_comb
  begin
    next_base_page = base_page;
    next_next_pg = next_pg;
    next_lp_np_able = lp_np_able;
    next_an_able = lp_an_able; // R14
    if (page_rx_evt)
    begin
      if (page_is_next)
      begin
        next_next_pg = rx_word; // R13 R15
      end
      else
      begin
        // Bits 15..0 copied; bit 12 reserved forced low
        next_base_page = rx_word & `ANPS_BASE_RSVD_MASK; // R1 R2 R3 R4 R5 R13 R16
        next_lp_np_able = rx_word[`ANPS_BIT_LP_NP]; // R9
      end
    end
  end

  // Register stage for page storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      base_page <= `ANPS_ZERO16;
      next_pg <= `ANPS_ZERO16;
      lp_np_able <= 1'b0;
      an_able <= 1'b0;
      local_np <= `ANPS_LOCAL_NP_RESET; // R10
    end
    else
    begin
      base_page <= next_base_page;
      next_pg <= next_next_pg;
      lp_np_able <= next_lp_np_able;
      an_able <= next_an_able;
      // Held constant; kept as a register so that reset alone gives its value
      local_np <= local_np;
    end
  end

  // Read mux; base page flag only meaningful in alternate mode
  always_comb
  begin
    next_rd_data = `ANPS_ZERO16;
    if (rd_en)
    begin
      unique case (rd_addr)
        `ANPS_ADDR_BASE: next_rd_data = base_page;
        `ANPS_ADDR_NEXT: next_rd_data = next_pg;
        `ANPS_ADDR_EXP:
        begin
          next_rd_data[`ANPS_BIT_ANABLE] = an_able; // R14
          next_rd_data[`ANPS_BIT_PAGE_RX] = latch_high_page_rx; // R11
          next_rd_data[`ANPS_BIT_NP_ABLE] = local_np; // R10
          next_rd_data[`ANPS_BIT_LP_NP_ABLE] = lp_np_able; // R9
          next_rd_data[`ANPS_BIT_PD_FAULT] = pd_flag; // R8
          next_rd_data[`ANPS_BIT_BASE_PAGE] = base_flag && alt_np_en; // R6
        end
        default: next_rd_data = `ANPS_ZERO16;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data <= `ANPS_ZERO16;
    end
    else
    begin
      rd_data <= next_rd_data;
    end
  end

  // More-pages bit of the stored next page, shown without a read
  assign next_page_flag = next_pg[`ANPS_BIT_LP_NP]; // R15

  // Checks on storage of received pages
  a_page_store: assert property (@(posedge clk) disable iff (!rst_n) // R13
    page_rx_evt && !page_is_next |=> base_page == ($past(rx_word) & `ANPS_BASE_RSVD_MASK))
    else $error("base page not stored");
  a_np_store: assert property (@(posedge clk) disable iff (!rst_n) // R13
    page_rx_evt && page_is_next |=> next_pg == $past(rx_word))
    else $error("next page not stored");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n) // R16
    base_page[`ANPS_BIT_RSVD] == 1'b0)
    else $error("reserved bit set");
  // Latched flags set on their events and hold until cleared
  a_rx_set: assert property (@(posedge clk) disable iff (!rst_n) // R11
    page_rx_evt && !alt_clr |=> latch_high_page_rx)
    else $error("page received not set");
  a_rx_readclr: assert property (@(posedge clk) disable iff (!rst_n) // R11
    exp_rd && !page_rx_evt |=> !latch_high_page_rx)
    else $error("page received not cleared");
  a_rx_hold: assert property (@(posedge clk) disable iff (!rst_n) // R11
    latch_high_page_rx && !exp_rd && !alt_clr |=> latch_high_page_rx)
    else $error("page received dropped");
  a_alt_clear: assert property (@(posedge clk) disable iff (!rst_n) // R12
    alt_clr |=> !latch_high_page_rx)
    else $error("alternate clear missed");
  a_base_set: assert property (@(posedge clk) disable iff (!rst_n) // R7
    base_page_evt |=> base_flag)
    else $error("base page flag not set");
  a_pdf_set: assert property (@(posedge clk) disable iff (!rst_n) // R8
    pd_fault_evt |=> pd_flag)
    else $error("fault flag not set");
  a_pdf_hold: assert property (@(posedge clk) disable iff (!rst_n) // R8
    pd_flag && !exp_rd |=> pd_flag)
    else $error("fault flag dropped");
  // Partner abilities and read data as software sees them
  a_lp_np: assert property (@(posedge clk) disable iff (!rst_n) // R9
    page_rx_evt && !page_is_next |=> lp_np_able == $past(rx_word[`ANPS_BIT_LP_NP]))
    else $error("partner next page able wrong");
  a_local_np: assert property (@(posedge clk) disable iff (!rst_n) // R10
    exp_rd |=> rd_data[`ANPS_BIT_NP_ABLE])
    else $error("local next page able low");
  a_an_able: assert property (@(posedge clk) disable iff (!rst_n) // R14
    exp_rd |=> rd_data[`ANPS_BIT_ANABLE] == $past(an_able))
    else $error("autoneg able bit wrong");
  a_base_gate: assert property (@(posedge clk) disable iff (!rst_n) // R6
    exp_rd && !alt_np_en |=> !rd_data[`ANPS_BIT_BASE_PAGE])
    else $error("base page bit shown outside alternate mode");
  a_exp_read: assert property (@(posedge clk) disable iff (!rst_n) // R8
    exp_rd ##1 1'b1 |-> rd_data[`ANPS_BIT_PD_FAULT] == $past(pd_flag))
    else $error("expansion read wrong");
  // Between reads the bus is quiet, so a stale word is never taken for an answer
  a_rd_idle: assert property (@(posedge clk) disable iff (!rst_n) // R16
    !rd_en |=> rd_data == `ANPS_ZERO16)
    else $error("read data not idle");
  // Scenario covers
  c_base_rx: cover property (@(posedge clk) page_rx_evt && !page_is_next);
  c_next_rx: cover property (@(posedge clk) page_rx_evt && page_is_next);
  c_rd_clr: cover property (@(posedge clk) latch_high_page_rx ##1 exp_rd);
  c_alt: cover property (@(posedge clk) latch_high_page_rx && alt_clr);
  c_pd_fault: cover property (@(posedge clk) pd_fault_evt ##1 exp_rd);
endmodule
`default_nettype wire

// ==== bench/anps_link_partner.sv ====
// Behavioural remote partner that delivers received pages
`timescale 1ns/1ps
`default_nettype none
module anps_link_partner
  import anps_pkg::*;
(
  // Clock
  input wire logic clk,
  // Page delivery
  output logic page_rx_evt,
  output logic page_is_next,
  output anps_word_t rx_word
);
  // Quiet lines at start
  initial
  begin
    page_rx_evt = 1'b0;
    page_is_next = 1'b0;
    rx_word = 16'h0000;
  end
  // One page; word inverted after strobe so a late sample is caught
  task automatic send(input anps_word_t w, input logic nx);
    @(negedge clk);
    page_rx_evt = 1'b1;
    page_is_next = nx;
    rx_word = w;
    @(negedge clk);
    page_rx_evt = 1'b0;
    rx_word = ~w;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_anps_regs.sv ====
// Self-checking bench for the partner status registers
`timescale 1ns/1ps
`default_nettype none
module tb_anps_regs;
  import anps_pkg::*;
  logic clk, rst_n, rd_en, base_page_evt, pd_fault_evt, lp_an_able, mr_page_rx;
  logic transmit_disable, alt_np_en, page_rx_evt, page_is_next;
  logic latch_high_page_rx, next_page_flag;
  anps_addr_t rd_addr;
  anps_word_t rd_data, rx_word, base_m, next_m, w;
  // Shadow latched flags
  logic prx_m, pd_m, bp_m;
  int fail_count, samples_checked, cycles;
  logic [31:0] seed = 32'd16681;
  anps_regs i_anps_regs (.clk(clk), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .page_rx_evt(page_rx_evt), .page_is_next(page_is_next),
    .rx_word(rx_word), .base_page_evt(base_page_evt), .pd_fault_evt(pd_fault_evt),
    .lp_an_able(lp_an_able), .mr_page_rx(mr_page_rx), .transmit_disable(transmit_disable),
    .alt_np_en(alt_np_en), .latch_high_page_rx(latch_high_page_rx),
    .next_page_flag(next_page_flag));
  anps_link_partner i_anps_link_partner (.clk(clk), .page_rx_evt(page_rx_evt),
    .page_is_next(page_is_next), .rx_word(rx_word));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      summarize();
    end
  end
  function automatic anps_word_t xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Expected expansion word from shadows
  function automatic anps_word_t exp6();
    return {10'h000, bp_m & alt_np_en, pd_m, base_m[15], 1'b1, prx_m, lp_an_able};
  endfunction
  task automatic chk(input anps_word_t got, input anps_word_t e);
    samples_checked++;
    if (got !== e)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
      fail_count++;
    end
  endtask
  // Read strobe stays up so reads run back to back
  task automatic rd(input anps_addr_t a, input anps_word_t e);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    chk(rd_data, e);
    if (a == 5'h06)
    begin
      {prx_m, pd_m, bp_m} = 3'b000;
    end
  endtask
  task automatic idle();
    rd_en = 1'b0;
    @(negedge clk);
    chk(rd_data, 16'h0000);
  endtask
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {rst_n, rd_en, base_page_evt, pd_fault_evt, lp_an_able} = 5'b00000;
    {mr_page_rx, transmit_disable, alt_np_en, prx_m, pd_m, bp_m} = 6'b100000;
    {rd_addr, base_m, next_m} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(5'h06, 16'h0004);
    idle();
    lp_an_able = 1'b1;
    // Selector codes and all ability bits first, then random pages
    for (int i = 0; i < 20; i++)
    begin
      w = (i == 0) ? 16'hFFE1 : (i == 1) ? 16'h4002 : (i == 2) ? 16'h8000 : xs();
      if (i == 3) w = 16'h001F;
      if (i > 3 && w[0]) next_m = w;
      else base_m = w & 16'hEFFF;
      prx_m = 1'b1;
      i_anps_link_partner.send(w, i > 3 && w[0]);
      chk({15'h0000, latch_high_page_rx}, 16'h0001);
      chk({15'h0000, next_page_flag}, {15'h0000, next_m[15]});
      rd(5'h05, base_m);
      rd(5'h08, next_m);
      rd(5'h06, exp6());
      rd(5'h06, exp6());
      idle();
    end
    // Base page event outside alternate mode must stay hidden
    {pd_fault_evt, base_page_evt} = 2'b11;
    @(negedge clk);
    {pd_fault_evt, base_page_evt} = 2'b00;
    {pd_m, bp_m} = 2'b11;
    rd(5'h06, exp6());
    rd(5'h07, 16'h0000);
    idle();
    alt_np_en = 1'b1;
    base_page_evt = 1'b1;
    @(negedge clk);
    base_page_evt = 1'b0;
    bp_m = 1'b1;
    rd(5'h06, exp6());
    idle();
    // Page drop and transmitter off both clear the page flag
    for (int k = 0; k < 2; k++)
    begin
      next_m = 16'h0000;
      i_anps_link_partner.send(16'h0000, 1'b1);
      mr_page_rx = k[0];
      transmit_disable = k[0];
      @(negedge clk);
      chk({15'h0000, latch_high_page_rx}, 16'h0000);
      {mr_page_rx, transmit_disable} = 2'b10;
    end
    summarize();
  end
endmodule
`default_nettype wire
